// ### design/smbcs_pkg.sv
// constants, state and register layout for the smbus control/status flags
package smbcs_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCL_HALF_NS   = 5000;
    localparam int SCL_HALF_INT  =
        (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] SCL_HALF_CYCLES = 16'(SCL_HALF_INT);
    localparam logic [15:0] TMR_RESET       = 16'h0000;

    localparam int BIT_START    = 5;
    localparam int BIT_STOP     = 4;
    localparam int BIT_ACK_PEND = 3;
    localparam int BIT_ARB      = 2;
    localparam int BIT_ACK      = 1;
    localparam int BIT_SI       = 0;

    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam logic [3:0] CNT_RESET   = 4'h0;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic       LINE_IDLE   = 1'b1;
    localparam logic       DRIVE_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_GEN_START,
        ST_WAIT_FW,
        ST_RESTART,
        ST_START_SETUP,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_SLV_RX,
        ST_SLV_WAIT,
        ST_SLV_ACK
    } smbcs_state_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic       start;
        logic       stop;
        logic       ack_pend;
        logic       arb;
        logic       ack;
        logic       si;
    } smbcs_ctrl_t;
endpackage

// ### design/smbcs_flags.sv
// smbus control/status flags with the bus state machine they steer
// Notes on behaviour
// R1: start flag reads 1 once a start or repeated start is seen on the bus
// R2: writing 1 to start flag makes a start, or a repeated start mid-transfer
// R3: stop flag reads 1 on slave stop detection, or while master stop pending
// R4: writing 1 to stop flag as master makes a stop; hardware then clears it
// R5: arbitration lost flag reads 1 after an arbitration error, else 0
// R6: as master the ack bit captures ACK as 1, NACK as 0 after each byte
// R7: as slave ack bit 1 answers ACK, 0 NACK; SDA level is inverted bit
// R8: interrupt flag set when an operation completes and firmware must steer
// R9: while interrupt flag is set SCL is held low and the bus stalls
// R10: only firmware clears interrupt flag; clearing starts the next operation
// R11: ack request flag reads 1 while a received byte awaits ACK decision
`timescale 1ns/1ps
`default_nettype none
module smbcs_flags (
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 clk_en,
    input  wire logic                 reg_wr,
    input  wire logic [7:0]           reg_wdata,
    output var  smbcs_pkg::smbcs_ctrl_t reg_rdata,
    input  wire logic [7:0]           tx_byte,
    output logic      [7:0]           rx_byte,
    input  wire logic                 scl_i,
    output logic                      scl_o,
    output logic                      scl_oe,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe
);
    smbcs_pkg::smbcs_state_t state_ff;
    smbcs_pkg::smbcs_state_t nxt_state;
    smbcs_pkg::smbcs_ctrl_t  flags_ff;
    smbcs_pkg::smbcs_ctrl_t  nxt_flags;
    smbcs_pkg::smbcs_ctrl_t  rdata_ff;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic [15:0] tmr_ff;
    logic [7:0]  rx_byte_ff;
    logic        scl_m_ff;
    logic        scl_s_ff;
    logic        scl_d_ff;
    logic        sda_m_ff;
    logic        sda_s_ff;
    logic        sda_d_ff;
    logic        busy_ff;
    logic        master_ff;
    logic        scl_oe_ff;
    logic        sda_oe_ff;
    logic        nxt_scl_oe;
    logic        nxt_sda_oe;
    logic        line_ff;
    logic        start_seen;
    logic        stop_seen;
    logic        scl_rise;
    logic        scl_fall;
    logic        tmr_done;
    logic        slave_st;
    logic        wr;
    logic        si_clr;
    logic        ev_start_done;
    logic        ev_byte_done;
    logic        ev_arb;
    logic        ev_ack_sample;
    logic        ev_stop_done;
    logic        ev_slv_byte;
    logic        ev_slv_stop;

    // pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_m_ff <= smbcs_pkg::LINE_IDLE;
            scl_s_ff <= smbcs_pkg::LINE_IDLE;
            scl_d_ff <= smbcs_pkg::LINE_IDLE;
            sda_m_ff <= smbcs_pkg::LINE_IDLE;
            sda_s_ff <= smbcs_pkg::LINE_IDLE;
            sda_d_ff <= smbcs_pkg::LINE_IDLE;
        end else if (clk_en) begin
            scl_m_ff <= scl_i;
            scl_s_ff <= scl_m_ff;
            scl_d_ff <= scl_s_ff;
            sda_m_ff <= sda_i;
            sda_s_ff <= sda_m_ff;
            sda_d_ff <= sda_s_ff;
        end
    end

    assign start_seen = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    assign stop_seen  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
    assign scl_rise   = scl_s_ff & ~scl_d_ff;
    assign scl_fall   = ~scl_s_ff & scl_d_ff;
    assign tmr_done   = (tmr_ff == smbcs_pkg::SCL_HALF_CYCLES - 16'h0001);
    assign slave_st   = (state_ff == smbcs_pkg::ST_SLV_RX)
                      | (state_ff == smbcs_pkg::ST_SLV_WAIT)
                      | (state_ff == smbcs_pkg::ST_SLV_ACK);
    assign ev_slv_stop = slave_st & stop_seen;
    assign wr          = clk_en & reg_wr;
    assign si_clr      = reg_wr & ~reg_wdata[smbcs_pkg::BIT_SI];

    // half-period timer; high phases wait out a slave stretching scl
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tmr_ff <= smbcs_pkg::TMR_RESET;
        end else if (clk_en) begin
            if (nxt_state != state_ff) begin
                tmr_ff <= smbcs_pkg::TMR_RESET;
            end else if (!scl_s_ff && (state_ff == smbcs_pkg::ST_BIT_HIGH
                      || state_ff == smbcs_pkg::ST_START_SETUP
                      || state_ff == smbcs_pkg::ST_STOP_HIGH)) begin
                tmr_ff <= smbcs_pkg::TMR_RESET;
            end else if (!tmr_done) begin
                tmr_ff <= tmr_ff + 16'h0001;
            end
        end
    end

    always_comb begin
        nxt_state     = state_ff;
        nxt_shift     = shift_ff;
        nxt_cnt       = cnt_ff;
        ev_start_done = 1'b0;
        ev_byte_done  = 1'b0;
        ev_arb        = 1'b0;
        ev_ack_sample = 1'b0;
        ev_stop_done  = 1'b0;
        ev_slv_byte   = 1'b0;
        case (state_ff)
            smbcs_pkg::ST_IDLE: begin
                if (start_seen) begin
                    nxt_state = smbcs_pkg::ST_SLV_RX;
                    nxt_cnt   = smbcs_pkg::CNT_RESET;
                // R2: start only on a free bus
                end else if (flags_ff.start && !flags_ff.si && !busy_ff) begin
                    nxt_state = smbcs_pkg::ST_GEN_START;
                end
            end
            smbcs_pkg::ST_GEN_START: begin
                if (tmr_done) begin
                    nxt_state     = smbcs_pkg::ST_WAIT_FW;
                    ev_start_done = 1'b1;
                end
            end
            // R10: clearing si launches the next step
            smbcs_pkg::ST_WAIT_FW: begin
                if (!flags_ff.si) begin
                    if (flags_ff.stop) begin
                        nxt_state = smbcs_pkg::ST_STOP_LOW;
                    end else if (flags_ff.start) begin
                        nxt_state = smbcs_pkg::ST_RESTART;
                    end else begin
                        nxt_state = smbcs_pkg::ST_BIT_LOW;
                        nxt_shift = tx_byte;
                        nxt_cnt   = smbcs_pkg::CNT_RESET;
                    end
                end
            end
            smbcs_pkg::ST_RESTART: begin
                if (tmr_done) begin
                    nxt_state = smbcs_pkg::ST_START_SETUP;
                end
            end
            smbcs_pkg::ST_START_SETUP: begin
                if (tmr_done) begin
                    nxt_state = smbcs_pkg::ST_GEN_START;
                end
            end
            smbcs_pkg::ST_BIT_LOW: begin
                if (tmr_done) begin
                    nxt_state = smbcs_pkg::ST_BIT_HIGH;
                end
            end
            smbcs_pkg::ST_BIT_HIGH: begin
                if (tmr_done) begin
                    if (cnt_ff == smbcs_pkg::ACK_SLOT) begin
                        nxt_state     = smbcs_pkg::ST_WAIT_FW;
                        ev_ack_sample = 1'b1;
                        ev_byte_done  = 1'b1;
                    // R5: released a one but the line reads low
                    end else if (shift_ff[7] && !sda_s_ff) begin
                        nxt_state = smbcs_pkg::ST_IDLE;
                        ev_arb    = 1'b1;
                    end else begin
                        nxt_state = smbcs_pkg::ST_BIT_LOW;
                        nxt_shift = {shift_ff[6:0], 1'b1};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end
                end
            end
            smbcs_pkg::ST_STOP_LOW: begin
                if (tmr_done) begin
                    nxt_state = smbcs_pkg::ST_STOP_HIGH;
                end
            end
            smbcs_pkg::ST_STOP_HIGH: begin
                if (tmr_done) begin
                    nxt_state    = smbcs_pkg::ST_IDLE;
                    ev_stop_done = 1'b1;
                end
            end
            smbcs_pkg::ST_SLV_RX: begin
                if (scl_rise && cnt_ff != smbcs_pkg::ACK_SLOT) begin
                    nxt_shift = {shift_ff[6:0], sda_s_ff};
                    nxt_cnt   = cnt_ff + 4'h1;
                end else if (scl_fall && cnt_ff == smbcs_pkg::ACK_SLOT) begin
                    nxt_state   = smbcs_pkg::ST_SLV_WAIT;
                    ev_slv_byte = 1'b1;
                end
            end
            smbcs_pkg::ST_SLV_WAIT: begin
                if (!flags_ff.si) begin
                    nxt_state = smbcs_pkg::ST_SLV_ACK;
                end
            end
            smbcs_pkg::ST_SLV_ACK: begin
                if (scl_fall) begin
                    nxt_state = smbcs_pkg::ST_SLV_RX;
                    nxt_cnt   = smbcs_pkg::CNT_RESET;
                end
            end
            default: begin
                nxt_state = smbcs_pkg::ST_IDLE;
            end
        endcase
        if (slave_st && stop_seen) begin
            nxt_state = smbcs_pkg::ST_IDLE;
        end else if (slave_st && start_seen) begin
            nxt_state = smbcs_pkg::ST_SLV_RX;
            nxt_cnt   = smbcs_pkg::CNT_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff   <= smbcs_pkg::ST_IDLE;
            shift_ff   <= smbcs_pkg::BYTE_RESET;
            cnt_ff     <= smbcs_pkg::CNT_RESET;
            rx_byte_ff <= smbcs_pkg::BYTE_RESET;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff   <= nxt_cnt;
            if (ev_slv_byte) begin
                rx_byte_ff <= shift_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_ff   <= 1'b0;
            master_ff <= 1'b0;
        end else if (clk_en) begin
            busy_ff   <= start_seen | (busy_ff & ~stop_seen);
            master_ff <= (nxt_state == smbcs_pkg::ST_GEN_START)
                       | (master_ff & ~ev_stop_done & ~ev_arb);
        end
    end

    // hardware sets win over firmware clears in the same cycle
    always_comb begin
        nxt_flags      = flags_ff;
        nxt_flags.rsvd = 2'h0;
        if (reg_wr) begin
            nxt_flags.start = reg_wdata[smbcs_pkg::BIT_START];
            nxt_flags.ack   = reg_wdata[smbcs_pkg::BIT_ACK];
            nxt_flags.si    = reg_wdata[smbcs_pkg::BIT_SI];
        end
        // R1: detection sets the start flag
        if (start_seen) begin
            nxt_flags.start = 1'b1;
        end
        // R4: master stop clears itself when done
        if (ev_stop_done) begin
            nxt_flags.stop = 1'b0;
        end
        if (reg_wr) begin
            nxt_flags.stop = reg_wdata[smbcs_pkg::BIT_STOP];
        end
        // R3: slave side stop detection
        if (ev_slv_stop) begin
            nxt_flags.stop = 1'b1;
        end
        // R6: master capture, line low is ack
        if (ev_ack_sample) begin
            nxt_flags.ack = ~sda_s_ff;
        end
        if (si_clr) begin
            nxt_flags.arb      = 1'b0;
            nxt_flags.ack_pend = 1'b0;
        end
        // R5: sticky until firmware clears si
        if (ev_arb) begin
            nxt_flags.arb = 1'b1;
        end
        // R11: decision pending on received byte
        if (ev_slv_byte) begin
            nxt_flags.ack_pend = 1'b1;
        end
        // R8: operation complete
        if (ev_start_done | ev_byte_done | ev_arb | ev_slv_byte) begin
            nxt_flags.si = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_ff <= smbcs_pkg::CTRL_RESET;
            rdata_ff <= smbcs_pkg::CTRL_RESET;
        end else if (clk_en) begin
            flags_ff <= nxt_flags;
            rdata_ff <= nxt_flags;
        end
    end

    always_comb begin
        // R9: si alone is enough to pull scl low
        // wait state keeps scl low after si clears, so no spike before the next step
        nxt_scl_oe = nxt_flags.si
                   | (nxt_state == smbcs_pkg::ST_WAIT_FW)
                   | (nxt_state == smbcs_pkg::ST_BIT_LOW)
                   | (nxt_state == smbcs_pkg::ST_RESTART)
                   | (nxt_state == smbcs_pkg::ST_STOP_LOW)
                   | (nxt_state == smbcs_pkg::ST_SLV_WAIT);
        case (nxt_state)
            smbcs_pkg::ST_GEN_START,
            smbcs_pkg::ST_STOP_LOW,
            smbcs_pkg::ST_STOP_HIGH: begin
                nxt_sda_oe = 1'b1;
            end
            // new bit one cycle after scl falls, never on the same edge
            smbcs_pkg::ST_BIT_LOW: begin
                nxt_sda_oe = (state_ff == smbcs_pkg::ST_BIT_LOW)
                           ? (cnt_ff != smbcs_pkg::ACK_SLOT) & ~shift_ff[7]
                           : sda_oe_ff;
            end
            smbcs_pkg::ST_BIT_HIGH,
            smbcs_pkg::ST_WAIT_FW: begin
                nxt_sda_oe = sda_oe_ff;
            end
            // R7: ack bit 1 pulls sda low
            smbcs_pkg::ST_SLV_ACK: begin
                nxt_sda_oe = nxt_flags.ack;
            end
            default: begin
                nxt_sda_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_oe_ff <= smbcs_pkg::DRIVE_RESET;
            sda_oe_ff <= smbcs_pkg::DRIVE_RESET;
            line_ff   <= smbcs_pkg::DRIVE_RESET;
        end else if (clk_en) begin
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            line_ff   <= smbcs_pkg::DRIVE_RESET;
        end
    end

    assign reg_rdata = rdata_ff;
    assign rx_byte   = rx_byte_ff;
    assign scl_o     = line_ff;
    assign sda_o     = line_ff;
    assign scl_oe    = scl_oe_ff;
    assign sda_oe    = sda_oe_ff;

    a_start_detect: assert property (@(posedge ref_clk) disable iff (srst) // R1
        (start_seen && clk_en) |=> flags_ff.start)
        else $error("start seen but start flag clear");
    a_start_launch: assert property (@(posedge ref_clk) disable iff (srst) // R2
        (clk_en && state_ff == smbcs_pkg::ST_IDLE && flags_ff.start
         && !flags_ff.si && !busy_ff && !start_seen)
        |=> state_ff == smbcs_pkg::ST_GEN_START ##1 sda_oe_ff)
        else $error("start request not launched");
    a_stop_slave: assert property (@(posedge ref_clk) disable iff (srst) // R3
        (ev_slv_stop && clk_en) |=> flags_ff.stop && state_ff == smbcs_pkg::ST_IDLE)
        else $error("slave stop not flagged");
    a_stop_clear: assert property (@(posedge ref_clk) disable iff (srst) // R4
        (ev_stop_done && clk_en && !(reg_wr && reg_wdata[smbcs_pkg::BIT_STOP]))
        |=> !flags_ff.stop && !master_ff && !sda_oe_ff)
        else $error("stop flag not cleared after stop");
    a_arb_flag: assert property (@(posedge ref_clk) disable iff (srst) // R5
        (ev_arb && clk_en) |=> flags_ff.arb && flags_ff.si && !master_ff)
        else $error("arbitration loss not flagged");
    a_ack_capture: assert property (@(posedge ref_clk) disable iff (srst) // R6
        (ev_ack_sample && clk_en) |=> flags_ff.ack == !$past(sda_s_ff))
        else $error("ack not captured");
    a_ack_drive: assert property (@(posedge ref_clk) disable iff (srst) // R7
        (state_ff == smbcs_pkg::ST_SLV_ACK)
        |-> sda_oe_ff == flags_ff.ack)
        else $error("slave ack level wrong");
    a_si_on_byte: assert property (@(posedge ref_clk) disable iff (srst) // R8
        ((ev_byte_done || ev_slv_byte || ev_start_done) && clk_en) |=> flags_ff.si)
        else $error("si not set on completion");
    a_si_holds_scl: assert property (@(posedge ref_clk) disable iff (srst) // R9
        flags_ff.si |-> scl_oe_ff && (!$past(flags_ff.si) || $stable(state_ff)))
        else $error("scl released or state moved under si");
    a_si_sticky: assert property (@(posedge ref_clk) disable iff (srst) // R10
        (flags_ff.si && !(wr && si_clr)) |=> flags_ff.si)
        else $error("si cleared without firmware");
    a_ack_decision_pending_pair: assert property (@(posedge ref_clk) disable iff (srst) // R11
        flags_ff.ack_pend |-> flags_ff.si && state_ff == smbcs_pkg::ST_SLV_WAIT)
        else $error("ack request without pending byte");
endmodule
`default_nettype wire

// ### test/smbcs_bus_partner.sv
// far-side bus model: byte receiver with ack and arbitration, plus a fast master
`timescale 1ns/1ps
`default_nettype none
module smbcs_bus_partner (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    logic       m_scl    = 1'b0;
    logic       m_sda    = 1'b0;
    logic       ack_drv  = 1'b0;
    logic       slv_on   = 1'b0;
    logic       ack_en   = 1'b0;
    logic       arb_kill = 1'b0;
    logic [7:0] sh       = 8'h00;
    int         bitn     = 0;
    int         nstart   = 0;
    int         nstop    = 0;
    logic [7:0] rx_q[$];

    assign scl_low = m_scl;
    assign sda_low = m_sda | ack_drv | arb_kill;

    always @(negedge sda) if (scl === 1'b1) begin
        nstart++;
        bitn = 0;
    end
    always @(posedge sda) if (scl === 1'b1) nstop++;

    always @(posedge scl) if (slv_on) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        bitn++;
        if (bitn == 8) rx_q.push_back(sh);
    end
    always @(negedge scl) if (slv_on) begin
        if (bitn == 8) ack_drv = ack_en;
        else if (bitn >= 9) begin
            ack_drv = 1'b0;
            bitn = 0;
        end
    end

    // link half period of 32 ns; the clock stands high between frames
    task m_start();
        m_sda = 1'b1;
        #32;
        m_scl = 1'b1;
    endtask
    task m_bit(input logic b, output logic s);
        // data moves after scl has fallen, never on the same instant
        #8;
        m_sda = ~b;
        #24;
        m_scl = 1'b0;
        wait (scl === 1'b1);
        #16;
        s = sda;
        #16;
        m_scl = 1'b1;
    endtask
    task m_byte(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) m_bit(d[i], s);
        m_bit(1'b1, a);
    endtask
    task m_stop();
        m_scl = 1'b1;
        #32;
        m_sda = 1'b1;
        #32;
        m_scl = 1'b0;
        wait (scl === 1'b1);
        #32;
        m_sda = 1'b0;
        #32;
    endtask
endmodule
`default_nettype wire

// ### test/smbcs_flags_tb_top.sv
// self-checking bench for the smbus control/status flags
`timescale 1ns/1ps
`default_nettype none
module smbcs_flags_tb_top;
    logic                   ref_clk;
    logic                   srst;
    logic                   clk_en;
    logic                   reg_wr;
    logic [7:0]             reg_wdata;
    smbcs_pkg::smbcs_ctrl_t reg_rdata;
    logic [7:0]             tx_byte;
    logic [7:0]             rx_byte;
    logic                   scl_oe;
    logic                   sda_oe;
    logic                   scl_pin_o;
    logic                   sda_pin_o;
    logic                   p_scl_low;
    logic                   p_sda_low;
    logic                   scl_w;
    logic                   sda_w;
    logic [7:0]             rd;
    logic [7:0]             txb;
    logic [7:0]             sb;
    logic [7:0]             exp_q[$];
    logic                   seen;
    int                     n_mismatch  = 0;
    int                     comparisons = 0;

    assign rd    = reg_rdata;
    assign scl_w = (scl_oe ? scl_pin_o : 1'b1) & ~p_scl_low;
    assign sda_w = (sda_oe ? sda_pin_o : 1'b1) & ~p_sda_low;

    smbcs_flags dut (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .tx_byte   (tx_byte),
        .rx_byte   (rx_byte),
        .scl_i     (scl_w),
        .scl_o     (scl_pin_o),
        .scl_oe    (scl_oe),
        .sda_i     (sda_w),
        .sda_o     (sda_pin_o),
        .sda_oe    (sda_oe)
    );
    smbcs_bus_partner p (
        .scl     (scl_w),
        .sda     (sda_w),
        .scl_low (p_scl_low),
        .sda_low (p_sda_low)
    );

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d, input logic en = 1'b1);
        @(posedge ref_clk);
        clk_en    <= en;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        tx_byte   <= txb;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        clk_en <= 1'b1;
        #1;
    endtask
    // a wait that runs out shows up as a mismatch
    task automatic wait_bit(input int b, input logic v, input int lim, input string nm);
        for (int i = 0; i < lim; i++) begin
            if (rd[b] === v) break;
            @(posedge ref_clk);
            #1;
        end
        chk(nm, 8'(v), 8'(rd[b]));
    endtask
    task automatic mbyte(input logic [7:0] e);
        txb = 8'($urandom);
        exp_q.push_back(txb);
        wr(8'h00);
        wait_bit(0, 1'b1, 20000, "byte done");
        chk("byte on bus", exp_q.pop_front(), p.rx_q.pop_front());
        chk("byte flags", e, rd);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // about 46k cycles expected; allow nearly twice that
    initial begin
        #400000;
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end

    initial begin
        srst      = 1'b1;
        clk_en    = 1'b1;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        tx_byte   = 8'h00;
        txb       = 8'h00;
        void'($urandom(30112));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        p.nstart = 0;
        p.nstop  = 0;
        chk("reset flags", 8'h00, rd);
        chk("reset drive", 8'h00, {6'h00, scl_oe, sda_oe});
        chk("reset rx", 8'h00, rx_byte);
        $display("test reset done");

        wr(8'h01, 1'b0);
        chk("frozen write", 8'h00, rd);
        wr(8'hCE);
        chk("read-only bits", 8'h02, rd);
        wr(8'h00);
        chk("clear write", 8'h00, rd);
        $display("test register done");

        p.slv_on = 1'b1;
        p.ack_en = 1'b1;
        wr(8'h20);
        chk("start req", 8'h20, rd);
        wait_bit(0, 1'b1, 1100, "start done");
        chk("start flags", 8'h21, rd);
        chk("start lines", 8'h00, {6'h00, scl_w, sda_w});
        repeat (50) @(posedge ref_clk);
        #1;
        chk("stall scl", 8'h00, {7'h00, scl_w});
        mbyte(8'h03);
        p.ack_en = 1'b0;
        wr(8'h20);
        chk("restart req", 8'h20, rd);
        wait_bit(0, 1'b1, 3500, "restart done");
        chk("restart flags", 8'h21, rd);
        chk("start count", 8'h02, 8'(p.nstart));
        mbyte(8'h01);
        wr(8'h10);
        chk("stop pending", 8'h10, rd);
        wait_bit(4, 1'b0, 2500, "stop done");
        chk("stop flags", 8'h00, rd);
        chk("stop count", 8'h01, 8'(p.nstop));
        chk("stop lines", 8'h03, {6'h00, scl_w, sda_w});
        $display("test master done");

        p.slv_on = 1'b0;
        wr(8'h20);
        wait_bit(0, 1'b1, 1100, "arb start");
        txb = 8'h80 | 8'($urandom);
        p.arb_kill = 1'b1;
        wr(8'h00);
        wait_bit(0, 1'b1, 2500, "arb done");
        chk("arb flags", 8'h05, rd);
        chk("arb sda", 8'h00, {7'h00, sda_oe});
        p.arb_kill = 1'b0;
        wr(8'h00);
        chk("arb clear", 8'h00, rd);
        p.m_stop();
        $display("test arbitration done");

        p.m_start();
        for (int k = 0; k < 2; k++) begin
            sb = 8'($urandom);
            fork
                p.m_byte(sb, seen);
                begin
                    wait_bit(0, 1'b1, 300, "slave byte");
                    chk("slave rx", sb, rx_byte);
                    chk("slave flags", (k == 0) ? 8'h29 : 8'h0B, rd);
                    chk("slave stall", 8'h01, {7'h00, scl_oe});
                    wr((k == 0) ? 8'h02 : 8'h00);
                end
            join
            chk("slave ack line", (k == 0) ? 8'h00 : 8'h01, {7'h00, seen});
        end
        p.m_stop();
        repeat (10) @(posedge ref_clk);
        #1;
        chk("slave stop", 8'h10, rd);
        $display("test slave done");
        end_sim();
    end
endmodule
`default_nettype wire
